//--- rpu_unpack_cursor.sv
// rpu_unpack_cursor: frame buffer words to 24-bit pixels, cursor overlay,
// brightness pulse output and stream signature, plus its word FIFO
// assumes one clock, Avalon-MM master on the register port, FIFO feeder
`timescale 1ns/10ps

module rpu_fifo #(
    parameter int W = 64,
    parameter int D = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_in_data,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    output logic [W-1:0]      o_out_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;
    logic         in_ready_r;
    logic [AW:0]  level_nxt;

    assign empty = (wp_r == rp_r);
    assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    // ready is registered from the next fill level so the port comes from a flop
    assign level_nxt = (wp_r - rp_r) + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign o_in_ready = in_ready_r;
    assign o_out_valid = !empty;
    assign o_out_data = mem[rp_r[AW-1:0]];
    assign push = i_ce && i_in_valid && !full;
    assign pop = i_ce && i_out_ready && !empty;

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wp_r[AW-1:0]] <= i_in_data;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wp_r       <= '0;
            rp_r       <= '0;
            in_ready_r <= 1'b1;
        end
        else
        begin
            in_ready_r <= (level_nxt != (AW+1)'(D));
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
        end
    end

    chk_fifo_full_stall: assert property (@(posedge i_clk) disable iff (i_rst)
        full |-> !o_in_ready) else $error("fifo full but still ready");
endmodule

module rpu_unpack_cursor #(
    parameter int FIFO_DEPTH = 16,
    parameter int CUR_WORDS = 256
) (
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_ce,
    // register bus
    input  wire logic [rpu_pkg::AV_AW-1:0] i_avs_address,
    input  wire logic                     i_avs_read,
    input  wire logic                     i_avs_write,
    input  wire logic [31:0]              i_avs_writedata,
    input  wire logic [3:0]               i_avs_byteenable,
    output logic [31:0]                   o_avs_readdata,
    output logic                          o_avs_waitrequest,
    // frame buffer words
    input  wire logic [63:0]              i_fb_data,
    input  wire logic                     i_fb_valid,
    output logic                          o_fb_ready,
    // pixel stream
    output logic [23:0]                   o_pix_data,
    output logic                          o_pix_valid,
    output logic                          o_pix_sof,
    output logic                          o_pix_eol,
    input  wire logic                     i_pix_ready,
    // brightness
    output logic                          o_pwm
);
    import rpu_pkg::*;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[b*8 +: 8] = nw[b*8 +: 8];
        return r & mask;
    endfunction

    // bytes that must be buffered before one pixel can leave
    function automatic logic [4:0] bytes_needed(input logic [2:0] mode);
        case (mode)
            MODE_4BPP, MODE_8BPP: return 5'd1;
            MODE_16BPP:           return 5'd2;
            MODE_24BPP:           return 5'd3;
            default:              return 5'd4;
        endcase
    endfunction

    //--------------------------------------------------------------
    // register bus
    //--------------------------------------------------------------
    logic [31:0] ctrl_r, screen_r, cpos_r, csz_r, col1_r, col2_r, cadr_r, pwm_r;
    logic [31:0] sig_r, sig_frame_r, rd_nxt;
    logic [31:0] cur_mem [CUR_WORDS];
    logic        wait_r, acc, wr_go, img_sel;
    logic [10:0] x_r, y_r;
    logic        fifo_empty;

    assign acc = (i_avs_read || i_avs_write) && wait_r;
    assign wr_go = i_avs_write && !wait_r;
    assign img_sel = i_avs_address[11];
    assign o_avs_waitrequest = wait_r;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            wait_r <= 1'b1;
        else if (i_ce)
            wait_r <= !acc;
    end

    always_comb
    begin
        rd_nxt = 32'h0;
        case (i_avs_address)
            REG_CTRL:    rd_nxt = ctrl_r;
            REG_SCREEN:  rd_nxt = screen_r;
            REG_CUR_POS: rd_nxt = cpos_r;
            REG_CUR_SZ:  rd_nxt = csz_r;
            REG_CUR_C1:  rd_nxt = col1_r;
            REG_CUR_C2:  rd_nxt = col2_r;
            REG_CUR_ADR: rd_nxt = cadr_r;
            REG_PWM:     rd_nxt = pwm_r;
            REG_SIG:     rd_nxt = sig_frame_r;
            REG_STATUS:  rd_nxt = {fifo_empty, 4'h0, y_r, 5'h0, x_r};
            default:     rd_nxt = img_sel ? cur_mem[i_avs_address[9:2]] : 32'h0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_avs_readdata <= 32'h0;
        else if (i_ce && acc)
            o_avs_readdata <= rd_nxt;
    end

    // cursor setup is expected complete before the enable bit is set
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_r   <= CTRL_RST;
            screen_r <= SCREEN_RST;
            cpos_r   <= 32'h0;
            csz_r    <= 32'h0;
            col1_r   <= 32'h0;
            col2_r   <= 32'h0;
            cadr_r   <= 32'h0;
            pwm_r    <= PWM_RST;
        end
        else if (i_ce && wr_go)
        begin
            case (i_avs_address)
                REG_CTRL:    ctrl_r   <= be_merge(ctrl_r, i_avs_writedata, i_avs_byteenable, MASK_CTRL);
                REG_SCREEN:  screen_r <= be_merge(screen_r, i_avs_writedata, i_avs_byteenable, MASK_XY);
                REG_CUR_POS: cpos_r   <= be_merge(cpos_r, i_avs_writedata, i_avs_byteenable, MASK_XY);
                REG_CUR_SZ:  csz_r    <= be_merge(csz_r, i_avs_writedata, i_avs_byteenable, MASK_SZ);
                REG_CUR_C1:  col1_r   <= be_merge(col1_r, i_avs_writedata, i_avs_byteenable, MASK_COL);
                REG_CUR_C2:  col2_r   <= be_merge(col2_r, i_avs_writedata, i_avs_byteenable, MASK_COL);
                REG_CUR_ADR: cadr_r   <= be_merge(cadr_r, i_avs_writedata, i_avs_byteenable, MASK_ADR);
                REG_PWM:     pwm_r    <= be_merge(pwm_r, i_avs_writedata, i_avs_byteenable, MASK_PWM);
                default:     ;
            endcase
        end
    end

    // cursor bitmap store, 16 two-bit pixels per word, first pixel lowest
    always_ff @(posedge i_clk)
    begin
        if (i_ce && wr_go && img_sel)
            cur_mem[i_avs_address[9:2]] <= be_merge(cur_mem[i_avs_address[9:2]], i_avs_writedata,
                                                    i_avs_byteenable, 32'hffff_ffff);
    end

    //--------------------------------------------------------------
    // word fifo and byte unpacker
    //--------------------------------------------------------------
    logic [63:0]  f_data;
    logic         f_valid, f_pop;
    logic [127:0] buf_r;
    logic [4:0]   cnt_r, used, cnt_after;
    logic         half_r, fire;
    logic [2:0]   mode;
    logic [23:0]  raw;

    rpu_fifo #(.W(64), .D(FIFO_DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_in_data   (i_fb_data),
        .i_in_valid  (i_fb_valid),
        .o_in_ready  (o_fb_ready),
        .o_out_data  (f_data),
        .o_out_valid (f_valid),
        .i_out_ready (f_pop)
    );

    assign fifo_empty = !f_valid;
    assign mode = ctrl_r[2:0];
    assign fire = (cnt_r >= bytes_needed(mode)) && (!o_pix_valid || i_pix_ready);
    // 4 bpp frees its byte only after the low nibble has gone
    assign used = !fire ? 5'd0 : (mode == MODE_4BPP) ? {4'h0, half_r} : bytes_needed(mode);
    assign cnt_after = cnt_r - used;
    assign f_pop = f_valid && (cnt_after <= 5'd8);

    always_comb
    begin
        case (mode)
            MODE_4BPP:  raw = {20'h0, half_r ? buf_r[3:0] : buf_r[7:4]};
            MODE_8BPP:  raw = {16'h0, buf_r[7:0]};
            MODE_16BPP: raw = {8'h0, buf_r[15:0]};
            default:    raw = buf_r[23:0];
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            buf_r  <= 128'h0;
            cnt_r  <= 5'd0;
            half_r <= 1'b0;
        end
        else if (i_ce)
        begin
            buf_r <= (buf_r >> {used, 3'b000})
                   | (f_pop ? ({64'h0, f_data} << {cnt_after, 3'b000}) : 128'h0);
            cnt_r <= cnt_after + (f_pop ? 5'd8 : 5'd0);
            if (fire && mode == MODE_4BPP)
                half_r <= !half_r;
            else if (mode != MODE_4BPP)
                half_r <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // screen position and cursor overlay
    //--------------------------------------------------------------
    logic [10:0] scr_w, scr_h, cx, cy, dx, dy;
    logic [6:0]  cur_w, cur_h;
    logic [7:0]  cidx;
    logic [31:0] cword;
    logic [1:0]  code;
    logic        hit, sof;
    logic [23:0] merged;

    assign scr_w = screen_r[10:0];
    assign scr_h = screen_r[HI_LSB +: 11];
    assign cx = cpos_r[10:0];
    assign cy = cpos_r[HI_LSB +: 11];
    assign dx = x_r - cx;
    assign dy = y_r - cy;
    assign sof = (x_r == 11'd0) && (y_r == 11'd0);
    // counters never leave the screen, so the clipping comes for free
    // sizes above 64 are held at 64, the largest cursor the bitmap rows cover
    assign cur_w = csz_r[6] ? 7'h40 : csz_r[6:0];
    assign cur_h = csz_r[HI_LSB + 6] ? 7'h40 : csz_r[HI_LSB +: 7];
    assign hit = ctrl_r[CTRL_CUR_EN] && (x_r >= cx) && (y_r >= cy)
              && (dx < {4'h0, cur_w}) && (dy < {4'h0, cur_h});
    assign cidx = cadr_r[7:0] + {dy[5:0], dx[5:4]};
    assign cword = cur_mem[cidx];
    assign code = cword[{dx[3:0], 1'b0} +: 2];

    always_comb
    begin
        merged = raw;
        if (hit)
        begin
            case (code)
                CUR_INVERT: merged = ~raw;
                CUR_COL1:   merged = col1_r[23:0];
                CUR_COL2:   merged = col2_r[23:0];
                default:    merged = raw;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            x_r <= 11'd0;
            y_r <= 11'd0;
        end
        else if (i_ce && fire)
        begin
            if (x_r >= scr_w - 11'd1)
            begin
                x_r <= 11'd0;
                y_r <= (y_r >= scr_h - 11'd1) ? 11'd0 : y_r + 11'd1;
            end
            else
                x_r <= x_r + 11'd1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pix_data  <= 24'h0;
            o_pix_valid <= 1'b0;
            o_pix_sof   <= 1'b0;
            o_pix_eol   <= 1'b0;
        end
        else if (i_ce)
        begin
            if (fire)
            begin
                o_pix_data  <= merged;
                o_pix_valid <= 1'b1;
                o_pix_sof   <= sof;
                o_pix_eol   <= (x_r >= scr_w - 11'd1);
            end
            else if (i_pix_ready)
                o_pix_valid <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // signature and brightness pulse
    //--------------------------------------------------------------
    logic [7:0] pwm_cnt_r;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sig_r       <= SIG_SEED;
            sig_frame_r <= 32'h0;
        end
        else if (i_ce && fire)
        begin
            // each frame starts from the seed; the finished frame is kept for reading
            if (sof)
            begin
                sig_frame_r <= sig_r;
                sig_r       <= SIG_SEED ^ {8'h0, merged};
            end
            else
                sig_r <= {sig_r[30:0], sig_r[31] ^ sig_r[21] ^ sig_r[1] ^ sig_r[0]} ^ {8'h0, merged};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pwm_cnt_r <= 8'h0;
            o_pwm     <= 1'b0;
        end
        else if (i_ce)
        begin
            if (ctrl_r[CTRL_PWM_SYNC] && fire && sof)
                pwm_cnt_r <= 8'h0;
            else
                pwm_cnt_r <= (pwm_cnt_r >= pwm_r[7:0]) ? 8'h0 : pwm_cnt_r + 8'h1;
            o_pwm <= (pwm_cnt_r < pwm_r[PWM_DUTY_LSB +: 8]);
        end
    end

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    chk_pix_32_word: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && fire && mode == MODE_32BPP && !hit) |=> o_pix_data == $past(buf_r[23:0]))
        else $error("32 bpp pixel mismatch");
    chk_pix_24_packed: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && fire && mode == MODE_24BPP && !hit) |=> (o_pix_data == $past(buf_r[23:0])) && o_pix_valid)
        else $error("24 bpp pixel mismatch");
    chk_pix_8_index: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && fire && mode == MODE_8BPP && !hit) |=> o_pix_data == {16'h0, $past(buf_r[7:0])})
        else $error("8 bpp pixel mismatch");
    chk_line_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && fire && x_r == scr_w - 11'd1) |=> x_r == 11'd0) else $error("line did not wrap");
    chk_pwm_duty: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce |=> o_pwm == ($past(pwm_cnt_r) < $past(pwm_r[15:8]))) else $error("pwm level wrong");
    chk_pwm_frame_sync: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && ctrl_r[CTRL_PWM_SYNC] && fire && sof) |=> pwm_cnt_r == 8'h0) else $error("pwm not restarted at frame");
    chk_cursor_colour: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && fire && hit && code == CUR_COL1) |=> o_pix_data == $past(col1_r[23:0]))
        else $error("cursor colour one missing");
    chk_cursor_invert: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && fire && hit && code == CUR_INVERT) |=> o_pix_data == ~$past(raw))
        else $error("cursor invert wrong");
    chk_cursor_clip: assert property (@(posedge i_clk) disable iff (i_rst)
        hit |-> (x_r < scr_w || scr_w == 11'd0) && dx < 11'd64 && dy < 11'd64) else $error("cursor escaped");
    chk_bus_answer: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && acc) |=> !o_avs_waitrequest) else $error("bus answer late");
    cov_frame_wrap: cover property (@(posedge i_clk) disable iff (i_rst) fire && sof ##1 o_pix_sof);
    cov_cursor_hit: cover property (@(posedge i_clk) disable iff (i_rst) fire && hit && code == CUR_COL2);
    cov_pix_stall: cover property (@(posedge i_clk) disable iff (i_rst) o_pix_valid && !i_pix_ready);
    cov_fifo_full: cover property (@(posedge i_clk) disable iff (i_rst) !o_fb_ready);
endmodule

//--- rpu_pkg.sv
// rpu_pkg: constants for the raster pixel unpack and cursor block
// assumes byte addresses on the register bus, 32-bit data
package rpu_pkg;
    localparam int AV_AW = 12;
    // register byte offsets
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_SCREEN  = 12'h004;
    localparam logic [11:0] REG_CUR_POS = 12'h008;
    localparam logic [11:0] REG_CUR_SZ  = 12'h00c;
    localparam logic [11:0] REG_CUR_C1  = 12'h010;
    localparam logic [11:0] REG_CUR_C2  = 12'h014;
    localparam logic [11:0] REG_CUR_ADR = 12'h018;
    localparam logic [11:0] REG_PWM     = 12'h01c;
    localparam logic [11:0] REG_SIG     = 12'h020;
    localparam logic [11:0] REG_STATUS  = 12'h024;
    localparam logic [11:0] CUR_IMG_BASE = 12'h800;
    // field positions
    localparam int CTRL_CUR_EN = 3;
    localparam int CTRL_PWM_SYNC = 4;
    localparam int HI_LSB = 16;
    localparam int PWM_DUTY_LSB = 8;
    // write masks, reserved bits read zero
    localparam logic [31:0] MASK_CTRL   = 32'h0000_001f;
    localparam logic [31:0] MASK_XY     = 32'h07ff_07ff;
    localparam logic [31:0] MASK_SZ     = 32'h007f_007f;
    localparam logic [31:0] MASK_COL    = 32'h00ff_ffff;
    localparam logic [31:0] MASK_ADR    = 32'h0000_00ff;
    localparam logic [31:0] MASK_PWM    = 32'h0000_ffff;
    // reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0005;
    localparam logic [31:0] SCREEN_RST  = 32'h0400_0500;
    localparam logic [31:0] PWM_RST     = 32'h0000_80ff;
    localparam logic [31:0] SIG_SEED    = 32'hffff_ffff;
    // pixel depth codes
    localparam logic [2:0] MODE_4BPP  = 3'h1;
    localparam logic [2:0] MODE_8BPP  = 3'h2;
    localparam logic [2:0] MODE_16BPP = 3'h3;
    localparam logic [2:0] MODE_24BPP = 3'h4;
    localparam logic [2:0] MODE_32BPP = 3'h5;
    // cursor pixel codes
    localparam logic [1:0] CUR_TRANSP = 2'h0;
    localparam logic [1:0] CUR_INVERT = 2'h1;
    localparam logic [1:0] CUR_COL1   = 2'h2;
    localparam logic [1:0] CUR_COL2   = 2'h3;
endpackage

//--- rpu_fb_feeder.sv
// rpu_fb_feeder: far-side model of the frame buffer word source
// assumes the bench fills its queue through put, one 64-bit item each
`timescale 1ns/10ps
module rpu_fb_feeder (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // word stream
    output logic [63:0]      o_data,
    output logic             o_valid,
    input  wire logic        i_ready
);
    logic [63:0] q[$];
    task automatic put(input logic [63:0] w);
        q.push_back(w);
    endtask
    // stalls at random; idle data toggles so nothing stale looks valid
    always @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_data  <= 64'h0;
        end
        else if (!o_valid || i_ready)
        begin
            if (q.size() > 0 && $urandom_range(3) != 0)
            begin
                o_data  <= q.pop_front();
                o_valid <= 1'b1;
            end
            else
            begin
                o_valid <= 1'b0;
                o_data  <= ~o_data;
            end
        end
endmodule

//--- rpu_unpack_cursor_bench.sv
// rpu_unpack_cursor_bench: self-checking bench with a queue model
// assumes rpu_pkg, the design and rpu_fb_feeder are compiled first
`timescale 1ns/10ps
module rpu_unpack_cursor_bench;
    import rpu_pkg::*;
    logic        clk = 0, rst = 1, rd = 0, wr = 0, prdy = 0, stall = 0;
    logic [11:0] adr = 0;
    logic [31:0] wd = 0, q, crow;
    logic [63:0] fbd;
    logic        fbv, fbr, pv, sof, eol, pwm, wrq;
    logic [23:0] pd, c1, c2;
    logic [31:0] rdat;
    logic [23:0] expq[$];
    logic [23:0] e;
    logic [31:0] msig = SIG_SEED, msig_done = 32'h0;
    int num_errors = 0, checks_done = 0, pix_n = 0;
    int cx = 0, cy = 0, cw = 0, ch = 0, hi;
    bit cur_en = 0;
    logic [2:0] mode = MODE_32BPP;
    int duty[3] = '{0, 3, 8};
    int xp[2] = '{0, 6};

    always #2.5 clk = ~clk;

    rpu_unpack_cursor rpu_unpack_cursor_inst (
        .i_clk(clk), .i_rst(rst), .i_ce(1'b1),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
        .i_fb_data(fbd), .i_fb_valid(fbv), .o_fb_ready(fbr),
        .o_pix_data(pd), .o_pix_valid(pv), .o_pix_sof(sof),
        .o_pix_eol(eol), .i_pix_ready(prdy), .o_pwm(pwm));
    rpu_fb_feeder rpu_fb_feeder_inst (
        .i_clk(clk), .i_rst(rst), .o_data(fbd), .o_valid(fbv), .i_ready(fbr));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic timeout(input string nm);
        num_errors++;
        $display("Error %s expected answer seen none", nm);
        report_and_stop();
    endtask
    // one Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wrq !== 1'b0 && n < 100);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 100)
            timeout("waitrequest");
    endtask
    function automatic logic [23:0] ovl(logic [23:0] p, int x, int y);
        int dx = x - cx;
        int dy = y - cy;
        if (!cur_en || dx < 0 || dy < 0 || dx >= cw || dy >= ch)
            return p;
        case (crow[2*dx+:2])
            CUR_INVERT: return ~p;
            CUR_COL1:   return c1;
            CUR_COL2:   return c2;
            default:    return p;
        endcase
    endfunction
    // frame signature model: seeded at pixel (0,0), then shift with feedback and fold in each pixel
    function automatic logic [31:0] sig_step(logic [31:0] s, logic [23:0] p, bit first);
        if (first)
            return SIG_SEED ^ {8'h0, p};
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]} ^ {8'h0, p};
    endfunction
    // one 8x2 frame of random bytes; model unpacks it per depth
    task automatic send_frame();
        logic [7:0]  b[$];
        logic [63:0] it;
        logic [23:0] p;
        int n;
        n = (mode == MODE_4BPP) ? 8 : (mode == MODE_8BPP) ? 16 :
            (mode == MODE_16BPP) ? 32 : (mode == MODE_24BPP) ? 48 : 64;
        repeat (n) b.push_back(8'($urandom));
        for (int i = 0; i < n / 8; i++)
        begin
            for (int j = 0; j < 8; j++)
                it[8*j+:8] = b[8*i+j];
            rpu_fb_feeder_inst.put(it);
        end
        for (int k = 0; k < 16; k++)
        begin
            case (mode)
                MODE_4BPP:  p = {20'h0, (k % 2) ? b[k/2][3:0] : b[k/2][7:4]};
                MODE_8BPP:  p = {16'h0, b[k]};
                MODE_16BPP: p = {8'h0, b[2*k+1], b[2*k]};
                MODE_24BPP: p = {b[3*k+2], b[3*k+1], b[3*k]};
                default:    p = {b[4*k+2], b[4*k+1], b[4*k]};
            endcase
            expq.push_back(ovl(p, k % 8, k / 8));
        end
    endtask
    task automatic drain(input string nm);
        int n;
        n = 0;
        while (expq.size() > 0 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000)
            timeout(nm);
        $display("test %s done", nm);
    endtask

    always @(posedge clk)
        prdy <= stall ? 1'b0 : ($urandom_range(3) != 0);
    always @(posedge clk)
        if (!rst && pv === 1'b1 && prdy === 1'b1)
        begin
            if (expq.size() == 0)
                chk("pixel count", 32'h0, 32'h1);
            else
            begin
                e = expq.pop_front();
                chk("pixel", {8'h0, e}, {8'h0, pd});
                if (pix_n == 0)
                    msig_done = msig;
                msig = sig_step(msig, e, pix_n == 0);
            end
            chk("sof", {31'h0, pix_n == 0}, {31'h0, sof});
            chk("eol", {31'h0, pix_n % 8 == 7}, {31'h0, eol});
            pix_n = (pix_n + 1) % 16;
        end

    initial
    begin
        void'($urandom(66934));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus(0, REG_CTRL, 0);
        chk("ctrl", CTRL_RST, q);
        bus(0, REG_SCREEN, 0);
        chk("screen", SCREEN_RST, q);
        bus(0, REG_PWM, 0);
        chk("pwm reg", PWM_RST, q);
        bus(1, 12'h3fc, 32'hffff_ffff);
        bus(0, 12'h3fc, 0);
        chk("unmapped", 32'h0, q);
        bus(1, REG_CUR_SZ, 32'hffff_ffff);
        bus(0, REG_CUR_SZ, 0);
        chk("cursor size", MASK_SZ, q);
        bus(1, REG_SCREEN, 32'h0002_0008);
        $display("test registers done");
        for (int m = 1; m <= 5; m++)
        begin
            mode = 3'(m);
            bus(1, REG_CTRL, {29'h0, mode});
            send_frame();
            drain("depth");
        end
        bus(0, REG_SIG, 0);
        chk("signature", msig_done, q);
        crow = 32'h0000_00e4;
        c1 = 24'h12_3456;
        c2 = 24'ha5_5a0f;
        foreach (xp[i])
        begin
            cx = xp[i];
            cy = 1;
            cw = 4;
            ch = 4;
            bus(1, CUR_IMG_BASE, crow);
            bus(1, REG_CUR_ADR, 0);
            bus(1, REG_CUR_C1, {8'h0, c1});
            bus(1, REG_CUR_C2, {8'h0, c2});
            bus(1, REG_CUR_POS, {16'(cy), 16'(cx)});
            bus(1, REG_CUR_SZ, 32'h0004_0004);
            bus(1, REG_CTRL, 32'h0000_000d);
            cur_en = 1;
            send_frame();
            drain("cursor");
        end
        bus(1, REG_CTRL, 32'h0000_0015);
        cur_en = 0;
        stall = 1;
        repeat (3) send_frame();
        hi = 0;
        while (fbr !== 1'b0 && hi < 500)
        begin
            @(posedge clk);
            hi++;
        end
        chk("fifo full", 32'h0, {31'h0, fbr});
        stall = 0;
        drain("fifo");
        bus(0, REG_STATUS, 0);
        chk("status", 32'h8000_0000, q);
        foreach (duty[i])
        begin
            bus(1, REG_PWM, {16'h0, 8'(duty[i]), 8'h07});
            repeat (300) @(posedge clk);
            hi = 0;
            repeat (64)
            begin
                @(posedge clk);
                if (pwm === 1'b1)
                    hi++;
            end
            chk("pwm high", (duty[i] > 8 ? 8 : duty[i]) * 8, hi);
        end
        $display("test pwm done");
        report_and_stop();
    end
endmodule
